// file: hdl/seq_pkg.sv
// Package with the constants and state type of the rail start-up fault sequencer.
package seq_pkg;

	// ************************************************************
	// Counts and timing.
	// ************************************************************
	localparam int unsigned PEAK_COUNT_DONE = 6;     // Peaks seen before monitoring starts.
	localparam int unsigned PEAK_INIT_DONE  = 2;     // Peaks that close the two check ramps.
	localparam int unsigned PEAK_GATE_LOW   = 4;     // Peak that enables the gate-low rail.
	localparam int unsigned PEAK_DELAYED    = 5;     // Peak that drives the delayed switch.
	localparam int unsigned PEAK_W          = 3;     // Width of the peak counter.
	localparam int unsigned CLK_HZ          = 20000000; // Reference clock rate.
	localparam int unsigned FAULT_TIMEOUT_MS = 50;   // Fault timeout with the typical capacitor.
	localparam int unsigned SOFT_START_MS   = 2;     // Soft-start time with the typical capacitor.
	localparam int unsigned MS_DIV          = 1000;  // Milliseconds per second.
	localparam int unsigned FAULT_TIMEOUT_CYC = FAULT_TIMEOUT_MS * (CLK_HZ / MS_DIV);
	localparam int unsigned SOFT_START_CYC  = SOFT_START_MS * (CLK_HZ / MS_DIV);
	localparam int unsigned TIMER_W         = 24;    // Width of the timeout counter.
	localparam int unsigned SYNC_W          = 14;    // Number of inputs in the shared synchroniser bank.

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_OFF,        // Supply invalid, nothing on.
		ST_WAIT_EN,    // Reference and logic rail on, waiting for enable.
		ST_RAMP_UP,    // Delay capacitor charging to the upper threshold.
		ST_RAMP_DOWN,  // Delay capacitor discharging to the lower threshold.
		ST_MONITOR,    // Sequence done, capacitor held at the hold level.
		ST_TIMEOUT,    // Output fault, linear timeout ramp running.
		ST_LATCHED     // Fault latched, every rail but the reference off.
	} seq_state_t;

endpackage

// file: hdl/sync2.sv
// Two-flop synchroniser bank for the asynchronous comparator and pin inputs.
`timescale 1ns/1ps
module sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	// First stage, read only by the second stage.
	logic [W-1:0] meta_ff;

	// ************************************************************
	// Synchroniser flops.
	// ************************************************************

	// Both stages clear to zero, so the reference and feedback inputs read as faulted from reset.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

// file: hdl/lcd_rail_startup_fault_sequencer.sv
// Start-up sequencer and fault supervisor for a multi-rail display supply.
`timescale 1ns/1ps
module lcd_rail_startup_fault_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = FAULT_TIMEOUT_CYC // Fault timeout in clock cycles.
) (
	input  wire logic ref_clk,                 // Reference clock, 20 MHz.
	input  wire logic rst_n,                   // Asynchronous reset, active low.
	input  wire logic supply_valid,            // Input supply above 2.5V.
	input  wire logic enable_pin,              // Enable pin level.
	input  wire logic cap_upper,               // Delay capacitor above upper threshold.
	input  wire logic cap_lower,               // Delay capacitor above lower threshold.
	input  wire logic cap_stuck,               // Delay capacitor pin shorted.
	input  wire logic ref_in_range,            // Reference within its window.
	input  wire logic over_temp,               // Die temperature above 140 C trip.
	input  wire logic power_good_output_low,   // Power-good pin below 0.6V.
	input  wire logic delayed_output_drive_low, // Delayed-drive pin below 0.6V.
	input  wire logic gate_high_feedback,      // Gate-high rail above under-voltage level.
	input  wire logic logic_rail_feedback,     // Logic rail above under-voltage level.
	input  wire logic gate_low_feedback,       // Gate-low rail above under-voltage level.
	input  wire logic boost_feedback,          // Boost above its fault threshold.
	input  wire logic over_target,             // Some regulated output above its target.
	input  wire logic integrator_cap_high,     // Integrator pin stuck high.
	output logic      reference_on,            // Reference enable.
	output logic      logic_rail_on,           // Logic rail enable.
	output logic      cap_charge_up,           // Charge the delay capacitor.
	output logic      cap_charge_down,         // Discharge the delay capacitor.
	output logic      cap_hold,                // Hold capacitor at the hold level.
	output logic      cap_timeout_ramp,        // Slow linear timeout ramp current.
	output logic      power_good_output_o,     // Power-good pin drive value (low).
	output logic      power_good_output_oe_n,  // Power-good output enable, low drives.
	output logic      delayed_output_drive_o,  // Delayed-drive pin drive value (low).
	output logic      delayed_output_drive_oe_n, // Delayed-drive output enable, low drives.
	output logic      boost_soft_start,        // Boost enabled with soft-start.
	output logic      gate_low_rail_on,        // Gate-low rail enable.
	output logic      gate_high_rail_on,       // Gate-high rail enable.
	output logic      regulator_drive_gate,    // Drives paused for an over-target output.
	output logic      boost_p_mode,            // Boost loop in proportional-only mode.
	output logic      fault_latched            // Fault latch status.
);

	// ************************************************************
	// Input synchronisation.
	// ************************************************************

	logic [SYNC_W-1:0] raw_in;   // Asynchronous inputs gathered.
	logic [SYNC_W-1:0] sync_in;  // Synchronised copies.

	assign raw_in = {supply_valid, enable_pin, cap_upper, cap_lower, cap_stuck, ref_in_range,
		over_temp, power_good_output_low, delayed_output_drive_low, gate_high_feedback,
		logic_rail_feedback, gate_low_feedback, boost_feedback, over_target};

	sync2 #(
		.W(SYNC_W)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	logic s_supply;  // Supply valid.
	logic s_en;      // Enable.
	logic s_up;      // Upper threshold.
	logic s_lo;      // Lower threshold.
	logic s_stuck;   // Capacitor pin shorted.
	logic s_ref;     // Reference good.
	logic s_hot;     // Over temperature.
	logic s_pg_low;  // Power-good pin low.
	logic s_dl_low;  // Delayed-drive pin low.
	logic s_fbp;     // Gate-high feedback good.
	logic s_fbl;     // Logic feedback good.
	logic s_fbn;     // Gate-low feedback good.
	logic s_fbb;     // Boost feedback good.
	logic s_over;    // Output above target.
	logic s_integrator_cap;    // Integrator pin high.

	assign {s_supply, s_en, s_up, s_lo, s_stuck, s_ref, s_hot, s_pg_low, s_dl_low, s_fbp,
		s_fbl, s_fbn, s_fbb, s_over} = sync_in;

	// The integrator strap takes its two synchroniser stages inside the state struct below.
	// It is kept out of the shared bank, whose width is the package's input count.

	// ************************************************************
	// State.
	// ************************************************************

	typedef struct packed {
		seq_state_t         state;    // Sequencer state.
		logic [PEAK_W-1:0]  peaks;    // Peaks counted so far.
		logic [TIMER_W-1:0] timer;    // Timeout ramp counter.
		logic               en_prev;  // Enable seen last cycle.
		logic               pg_on;    // Power-good driven low.
		logic               dl_on;    // Delayed drive driven low.
		logic               boost;    // Boost running.
		logic               gate_low_rail;     // Gate-low rail on.
		logic               gate_high_rail;      // Gate-high rail on.
		logic               checked;  // Early reference and temperature check passed.
		logic               integrator_cap_meta; // Integrator pin, first synchroniser stage.
		logic               integrator_cap;      // Integrator pin, second synchroniser stage.
	} seq_regs_t;

	seq_regs_t cur_ff;   // Registered state.
	seq_regs_t nxt_cur;  // Next state.

	// Proportional-only mode follows the second strap stage; only it is read by logic.
	assign s_integrator_cap = cur_ff.integrator_cap;

	// Count as wide as the peak counter.
	function automatic logic [PEAK_W-1:0] pk(input int unsigned v);
		pk = v[PEAK_W-1:0];
	endfunction

	logic immediate_fault;  // Shut down without a timeout.
	logic output_fault;     // Fault that runs the timeout ramp.
	logic en_fall;          // Enable dropped this cycle.

	// Fault classes. Capacitor, reference and temperature faults skip the timeout ramp;
	// every output-level fault goes through the ramp first.
	always_comb begin
		immediate_fault = s_stuck || !s_ref || s_hot;
		output_fault = !s_pg_low || !s_dl_low || !s_fbp || !s_fbl || !s_fbn || !s_fbb;
		en_fall = cur_ff.en_prev && !s_en;
	end

	// ************************************************************
	// Next-state logic.
	// ************************************************************

	// Ramp decisions are made on threshold crossings seen by the comparators; the fault timeout ends on the timer count.
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.en_prev = s_en;
		if (!s_supply) begin
			// Loss of supply clears everything but the strap stages, including the fault latch.
			nxt_cur = '0;
			nxt_cur.state = ST_OFF;
		end else begin
			unique case (cur_ff.state)
				ST_OFF: begin
					nxt_cur.state = ST_WAIT_EN;
				end
				ST_WAIT_EN: begin
					// A shorted-low capacitor keeps the ramp from ever starting.
					if (s_en && !s_stuck) begin
						nxt_cur.state = ST_RAMP_UP;
					end
				end
				ST_RAMP_UP: begin
					if (!s_en) begin
						nxt_cur = '0;
						nxt_cur.state = ST_WAIT_EN;
					end else if (s_stuck || s_hot || (!cur_ff.checked && !s_ref)) begin
						nxt_cur.state = ST_LATCHED;
					end else if (s_up) begin
						// Upper crossing is a peak.
						nxt_cur.peaks = cur_ff.peaks + pk(1);
						if (cur_ff.peaks == pk(PEAK_INIT_DONE - 1)) begin
							nxt_cur.pg_on = 1'b1;
							nxt_cur.checked = 1'b1;
						end
						if (cur_ff.peaks == pk(PEAK_GATE_LOW - 1)) begin
							nxt_cur.gate_low_rail = 1'b1;
						end
						if (cur_ff.peaks == pk(PEAK_DELAYED - 1)) begin
							nxt_cur.dl_on = 1'b1;
						end
						if (cur_ff.peaks == pk(PEAK_COUNT_DONE - 1)) begin
							// End of the sixth ramp: check outputs before monitoring.
							nxt_cur.state = output_fault ? ST_TIMEOUT : ST_MONITOR;
						end else begin
							nxt_cur.state = ST_RAMP_DOWN;
						end
					end
				end
				ST_RAMP_DOWN: begin
					// A capacitor shorted high never drops below the lower level and stalls here.
					if (!s_en) begin
						nxt_cur = '0;
						nxt_cur.state = ST_WAIT_EN;
					end else if (s_stuck || s_hot || !s_ref) begin
						nxt_cur.state = ST_LATCHED;
					end else if (!s_lo) begin
						nxt_cur.state = ST_RAMP_UP;
						if (cur_ff.peaks == pk(PEAK_INIT_DONE)) begin
							nxt_cur.boost = 1'b1;
						end
						if (cur_ff.peaks == pk(PEAK_DELAYED)) begin
							nxt_cur.gate_high_rail = 1'b1;
						end
					end
				end
				ST_MONITOR: begin
					if (en_fall) begin
						nxt_cur = '0;
						nxt_cur.state = ST_WAIT_EN;
					end else if (immediate_fault) begin
						nxt_cur.state = ST_LATCHED;
					end else if (output_fault) begin
						nxt_cur.timer = '0;
						nxt_cur.state = ST_TIMEOUT;
					end
				end
				ST_TIMEOUT: begin
					if (en_fall) begin
						nxt_cur = '0;
						nxt_cur.state = ST_WAIT_EN;
					end else if (immediate_fault) begin
						nxt_cur.state = ST_LATCHED;
					end else if (!output_fault) begin
						nxt_cur.timer = '0;
						nxt_cur.state = ST_MONITOR;
					end else if (cur_ff.timer >= TIMER_W'(TIMEOUT_CYC - 1)) begin
						nxt_cur.state = ST_LATCHED;
					end else begin
						nxt_cur.timer = cur_ff.timer + TIMER_W'(1);
					end
				end
				ST_LATCHED: begin
					// An enable low, or a supply loss, releases the latch; low then parks us in ST_WAIT_EN.
					if (!s_en) begin
						nxt_cur = '0;
						nxt_cur.state = ST_WAIT_EN;
					end
				end
				default: begin
					nxt_cur = '0;
					nxt_cur.state = ST_OFF;
				end
			endcase
		end
		// The strap stages run whatever the sequencer does, so a supply loss never
		// leaves a stale mode; the first stage feeds nothing but the second.
		nxt_cur.integrator_cap_meta = integrator_cap_high;
		nxt_cur.integrator_cap = cur_ff.integrator_cap_meta;
	end

	// Register the whole state in one place.
	// Reset clears every field, so all rails come up off and the latch is open.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************

	logic latched;  // Fault latch active.
	logic run;      // Rails allowed to run.

	// Outputs decode from registered state; latched kills every rail but the reference.
	always_comb begin
		latched = (cur_ff.state == ST_LATCHED);
		run = !latched && (cur_ff.state != ST_OFF);
		reference_on = (cur_ff.state != ST_OFF);
		logic_rail_on = run;
		cap_charge_up = (cur_ff.state == ST_RAMP_UP);
		cap_charge_down = (cur_ff.state == ST_RAMP_DOWN);
		cap_hold = (cur_ff.state == ST_MONITOR);
		cap_timeout_ramp = (cur_ff.state == ST_TIMEOUT);
		power_good_output_o = 1'b0;
		power_good_output_oe_n = !(run && cur_ff.pg_on);
		delayed_output_drive_o = 1'b0;
		delayed_output_drive_oe_n = !(run && cur_ff.dl_on);
		boost_soft_start = run && cur_ff.boost;
		gate_low_rail_on = run && cur_ff.gate_low_rail;
		gate_high_rail_on = run && cur_ff.gate_high_rail;
		regulator_drive_gate = run && s_over;
		boost_p_mode = s_integrator_cap;
		fault_latched = latched;
	end

endmodule

// file: tb/seq_monitor.sv
// Port-level concurrent checks for the rail start-up fault sequencer.
`timescale 1ns/1ps
module seq_monitor
	import seq_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = 20 // Timeout length handed on by the bind.
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic supply_valid,
	input wire logic enable_pin,
	input wire logic over_temp,
	input wire logic reference_on,
	input wire logic logic_rail_on,
	input wire logic cap_charge_up,
	input wire logic cap_charge_down,
	input wire logic cap_hold,
	input wire logic cap_timeout_ramp,
	input wire logic power_good_output_oe_n,
	input wire logic delayed_output_drive_oe_n,
	input wire logic boost_soft_start,
	input wire logic gate_low_rail_on,
	input wire logic gate_high_rail_on,
	input wire logic fault_latched
);
	// ****************************************
	// Timeout length counter and assertions.
	// ****************************************
	logic [TIMER_W-1:0] tmo_cnt_ff; // Cycles the timeout ramp has run.
	logic [TIMER_W-1:0] nxt_tmo_cnt; // Next count.

	// A counter keeps the long bound out of repetition operators.
	always_comb nxt_tmo_cnt = cap_timeout_ramp ? tmo_cnt_ff + 1'b1 : '0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_cnt_ff <= '0;
		end else begin
			tmo_cnt_ff <= nxt_tmo_cnt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	ref_first_a: assert property (cap_charge_up |-> reference_on && logic_rail_on)
		else $error("ramp started without reference and logic rail");
	enable_wait_a: assert property (!enable_pin [*4] |-> !cap_charge_up)
		else $error("ramp runs with enable low");
	latch_off_a: assert property (fault_latched |-> reference_on && !logic_rail_on
		&& !boost_soft_start && !gate_low_rail_on && !gate_high_rail_on
		&& power_good_output_oe_n && delayed_output_drive_oe_n)
		else $error("outputs on while latched");
	latch_keep_a: assert property ((fault_latched && enable_pin && supply_valid) [*3]
		|=> fault_latched) else $error("latch cleared without enable or supply cycle");
	boost_order_a: assert property (boost_soft_start |-> !power_good_output_oe_n)
		else $error("boost on before power-good drive");
	rail_order_a: assert property (gate_high_rail_on |-> gate_low_rail_on && boost_soft_start
		&& !delayed_output_drive_oe_n)
		else $error("gate-high rail out of order");
	hold_state_a: assert property (cap_hold |-> gate_high_rail_on && !cap_charge_up
		&& !cap_charge_down) else $error("hold level with ramp running");
	temp_trip_a: assert property ((cap_hold && over_temp && enable_pin && supply_valid) [*3]
		|=> fault_latched) else $error("over-temperature not latched at once");
	tmo_bound_a: assert property (tmo_cnt_ff <= TIMEOUT_CYC + 2)
		else $error("timeout ramp ran too long");
endmodule

bind lcd_rail_startup_fault_sequencer seq_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon_u (.*);

// file: tb/cap_pin_model.sv
// Behavioural delay capacitor and pulled-up open-drain pins facing the sequencer.
`timescale 1ns/1ps
module cap_pin_model #(
	parameter int TOP = 8 // Ramp steps from empty to the upper threshold.
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic charge_up,
	input  wire logic hold,
	input  wire logic stuck_high,
	input  wire logic pg_o,
	input  wire logic pg_oe_n,
	input  wire logic dd_o,
	input  wire logic dd_oe_n,
	output logic      cap_upper,
	output logic      cap_lower,
	output logic      pg_low,
	output logic      dd_low
);
	int level; // Capacitor voltage in ramp steps.

	// The capacitor leaks down whenever nothing charges or holds it.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 0;
		end else if (charge_up && level < TOP) begin
			level <= level + 1;
		end else if (!charge_up && !hold && level > 0) begin
			level <= level - 1;
		end
	end
	// A shorted pin shows both thresholds crossed.
	assign cap_upper = stuck_high || level >= TOP;
	assign cap_lower = stuck_high || level >= 2;
	// Pull-ups hold the pins high while the sequencer lets go.
	assign pg_low = !(pg_oe_n ? 1'b1 : pg_o);
	assign dd_low = !(dd_oe_n ? 1'b1 : dd_o);
endmodule

// file: tb/lcd_rail_startup_fault_sequencer_tb.sv
// Self-checking bench for the rail start-up fault sequencer.
`timescale 1ns/1ps
module lcd_rail_startup_fault_sequencer_tb;
	import seq_pkg::*;
	localparam int unsigned TMO = 20; // Shortened fault timeout.
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_valid, enable_pin, cap_stuck, ref_in_range, over_temp, stuck_high;
	logic gate_high_feedback, logic_rail_feedback, gate_low_feedback, boost_feedback;
	logic over_target, integrator_cap_high, cap_upper, cap_lower;
	logic power_good_output_low, delayed_output_drive_low, down_q;
	logic reference_on, logic_rail_on, cap_charge_up, cap_charge_down, cap_hold;
	logic cap_timeout_ramp, power_good_output_o, power_good_output_oe_n;
	logic delayed_output_drive_o, delayed_output_drive_oe_n, boost_soft_start;
	logic gate_low_rail_on, gate_high_rail_on, regulator_drive_gate, boost_p_mode;
	logic fault_latched;
	int fails = 0, cmp_count = 0, downs = 0, waited, fi, seed_r;

	lcd_rail_startup_fault_sequencer #(.TIMEOUT_CYC(TMO)) dut_u (.*);
	cap_pin_model far_u (.ref_clk(ref_clk), .rst_n(rst_n), .charge_up(cap_charge_up),
		.hold(cap_hold | cap_timeout_ramp), .stuck_high(stuck_high),
		.pg_o(power_good_output_o), .pg_oe_n(power_good_output_oe_n),
		.dd_o(delayed_output_drive_o), .dd_oe_n(delayed_output_drive_oe_n),
		.cap_upper(cap_upper), .cap_lower(cap_lower), .pg_low(power_good_output_low),
		.dd_low(delayed_output_drive_low));

	initial forever #25 ref_clk = ~ref_clk;
	// Reference count of ramp peaks, one per start of discharge.
	always @(posedge ref_clk) begin
		if (cap_charge_down === 1'b1 && down_q !== 1'b1) downs++;
		down_q = cap_charge_down;
	end

	// ****************************************
	// Shared tasks.
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return cap_hold;
			1: return fault_latched;
			2: return cap_charge_down;
			default: return cap_timeout_ramp;
		endcase
	endfunction
	// Bounded wait for one output level; the wait length is kept for timing checks.
	task automatic wait_sig(input int w, input logic v, input int lim);
		waited = 0;
		while (sig(w) !== v && waited < lim) begin
			tick(1);
			waited++;
		end
		chk(8'(sig(w)), 8'(v));
	endtask
	task automatic set_fb(input int i, input logic v);
		case (i)
			0: gate_high_feedback = v;
			1: logic_rail_feedback = v;
			2: gate_low_feedback = v;
			default: boost_feedback = v;
		endcase
	endtask
	// Full start-up: outputs checked against the peak count at each of the five peaks that start a discharge, then in hold.
	task automatic run_seq();
		downs = 0;
		for (int k = 1; k <= 5; k++) begin
			wait_sig(2, 1'b1, 200);
			tick(1);
			chk(8'({power_good_output_oe_n, boost_soft_start, gate_low_rail_on,
				delayed_output_drive_oe_n, gate_high_rail_on}),
				8'({k < 2, k >= 3, k >= 4, k < 5, 1'b0}));
			wait_sig(2, 1'b0, 200);
		end
		wait_sig(0, 1'b1, 200);
		chk(8'({power_good_output_o, delayed_output_drive_o, gate_high_rail_on, cap_charge_up,
			cap_charge_down}), 8'h04);
		chk(8'(downs), 8'h05);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	initial begin
		{supply_valid, enable_pin, cap_stuck, over_temp, stuck_high} = '0;
		{over_target, integrator_cap_high} = '0;
		{ref_in_range, gate_high_feedback, logic_rail_feedback} = '1;
		{gate_low_feedback, boost_feedback} = '1;
		seed_r = $urandom(32'h5f4269af);
		tick(16);
		rst_n = 1'b1;
		supply_valid = 1'b1;
		tick(10);
		chk(8'({reference_on, logic_rail_on, cap_charge_up}), 8'h06);
		enable_pin = 1'b1;
		run_seq();
		{over_target, integrator_cap_high} = 2'b11;
		tick(4);
		chk(8'({regulator_drive_gate, boost_p_mode}), 8'h03);
		{over_target, integrator_cap_high} = 2'b00;
		tick(4);
		chk(8'({regulator_drive_gate, boost_p_mode}), 8'h00);
		// Brief faults on every feedback end before the timeout.
		for (int i = 0; i < 4; i++) begin
			set_fb(i, 1'b0);
			wait_sig(3, 1'b1, 10);
			tick($urandom_range(2, TMO / 2));
			set_fb(i, 1'b1);
			wait_sig(0, 1'b1, 10);
			chk(8'(fault_latched), 8'h00);
		end
		fi = $urandom_range(0, 3);
		set_fb(fi, 1'b0);
		wait_sig(3, 1'b1, 10);
		wait_sig(1, 1'b1, TMO + 5);
		chk(8'(waited >= TMO - 2 && waited <= TMO + 2), 8'h01);
		set_fb(fi, 1'b1);
		tick(10);
		chk(8'({fault_latched, reference_on, cap_timeout_ramp}), 8'h06);
		enable_pin = 1'b0;
		tick(6);
		chk(8'(fault_latched), 8'h00);
		enable_pin = 1'b1;
		run_seq();
		// Immediate causes, each cleared by cycling the supply.
		for (int c = 0; c < 3; c++) begin
			{over_temp, ref_in_range, cap_stuck} = {c == 0, c != 1, c == 2};
			wait_sig(1, 1'b1, 6);
			{over_temp, ref_in_range, cap_stuck} = 3'b010;
			supply_valid = 1'b0;
			tick(6);
			chk(8'({reference_on, fault_latched}), 8'h00);
			supply_valid = 1'b1;
			run_seq();
		end
		enable_pin = 1'b0;
		tick(6);
		over_temp = 1'b1;
		enable_pin = 1'b1;
		wait_sig(1, 1'b1, 200);
		chk(8'({reference_on, boost_soft_start, power_good_output_oe_n}), 8'h05);
		over_temp = 1'b0;
		enable_pin = 1'b0;
		tick(6);
		cap_stuck = 1'b1;
		enable_pin = 1'b1;
		tick(50);
		chk(8'(cap_charge_up), 8'h00);
		stuck_high = 1'b1;
		cap_stuck = 1'b0;
		tick(200);
		chk(8'({cap_hold, boost_soft_start, gate_low_rail_on}), 8'h00);
		summarize();
	end

	// Watchdog far beyond the thousand or so cycles the scenarios need.
	initial begin
		#(50 * 20000);
		fails++;
		summarize();
	end
endmodule
